/* verilog/motor_protect_pkg.sv */
// shared constants and types for the motor protection block
package motor_protect_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL_ONE    = 8'h00;
    localparam logic [7:0] OFS_MODE_SEL    = 8'h04;
    localparam logic [7:0] OFS_CUT_PATTERN = 8'h08;
    localparam logic [7:0] OFS_HALL_CMP    = 8'h0C;
    localparam logic [7:0] OFS_STATUS      = 8'h10;
    localparam logic [7:0] OFS_HALL_COUNT  = 8'h14;

    // reset values
    localparam logic [7:0]  RST_CTRL_ONE    = 8'h00;
    localparam logic [7:0]  RST_MODE_SEL    = 8'h00;
    localparam logic [5:0]  RST_CUT_PATTERN = 6'h00;
    localparam logic [15:0] RST_HALL_CMP    = 16'hFFFF;

    // gate patterns, bit order {a_hi,a_lo,b_hi,b_lo,c_hi,c_lo}
    localparam logic [5:0] PATTERN_BRAKE    = 6'h15;
    localparam logic [5:0] PATTERN_FREE_RUN = 6'h00;

    // over-current filter length in system clocks
    localparam int OC_FILTER_CLOCKS = 2;

    // first control register, bit 7 down to bit 0
    typedef struct packed {
        logic sw_protect_data;
        logic sw_protect_enable;
        logic overflow_hw_trigger_enable;
        logic compare_hw_trigger_enable;
        logic overcurrent_hw_trigger_enable;
        logic limit_hw_trigger_enable;
        logic sw_cutoff_enable;
        logic hw_cutoff_enable;
    } ctrl_one_t;

    // mode select register, bit 7 down to bit 0
    typedef struct packed {
        logic hall_timer_enable;
        logic stop_style_select;
        logic sw_mode_select;
        logic limit_restart_select;
        logic overcurrent_mode_select;
        logic compare_mode_select;
        logic overflow_mode_select;
        logic reserved0;
    } mode_sel_t;

    // trigger events seen by the protect logic
    typedef struct packed {
        logic overcurrent_pulse;
        logic overcurrent_level;
        logic current_limit_event;
        logic hall_compare_event;
        logic hall_overflow_event;
    } trig_t;

    // status register, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] reserved;
        logic       limit_hold;
        logic       sw_pause;
        logic       overflow_pause;
        logic       compare_pause;
        logic       overcurrent_cutoff_active;
        logic       protect_active;
    } status_t;

endpackage : motor_protect_pkg

/* verilog/oc_pulse_filter.sv */
// over-current comparator synchroniser, two-clock filter and edge pulse
`timescale 1ns/1ps
module oc_pulse_filter
    import motor_protect_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_cmp_out,
    output logic      o_level,
    output logic      o_pulse
);
    logic [1:0]                  sync_ff;
    logic [OC_FILTER_CLOCKS-1:0] hist_ff;
    logic                        level_ff;
    logic                        pulse_ff;

    // two-stage synchroniser, comparator is asynchronous
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sync_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[0], i_cmp_out};
        end
    end

    // level moves only once the input held for the filter length
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hist_ff  <= '0;
            level_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            hist_ff  <= {hist_ff[OC_FILTER_CLOCKS-2:0], sync_ff[1]};
            if (&hist_ff) begin
                level_ff <= 1'b1;
            end else if (~|hist_ff) begin
                level_ff <= 1'b0;
            end
            pulse_ff <= (&hist_ff) & ~level_ff;
        end
    end

    assign o_level = level_ff;
    assign o_pulse = pulse_ff;
endmodule : oc_pulse_filter

/* verilog/hall_capture_timer.sv */
// WIDTH-bit (16 by default) hall period timer with compare and overflow events
`timescale 1ns/1ps
module hall_capture_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_enable,
    input  wire logic [2:0]       i_hall,
    input  wire logic [WIDTH-1:0] i_compare,
    output logic [WIDTH-1:0]      o_count,
    output logic                  o_compare_event,
    output logic                  o_overflow_event
);
    logic [2:0]       sync1_ff;
    logic [2:0]       sync2_ff;
    logic [2:0]       prev_ff;
    logic [WIDTH-1:0] count_ff;
    logic             cmp_ff;
    logic             ovf_ff;
    logic             hall_edge;

    // hall pins are asynchronous
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end else begin
            sync1_ff <= i_hall;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign hall_edge = |(prev_ff ^ sync2_ff);

    // count restarts on each hall change, saturates at full scale
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            count_ff <= '0;
            cmp_ff   <= 1'b0;
            ovf_ff   <= 1'b0;
        end else begin
            cmp_ff <= 1'b0;
            ovf_ff <= 1'b0;
            if (!i_enable || hall_edge) begin
                count_ff <= '0;
            end else if (count_ff != {WIDTH{1'b1}}) begin
                count_ff <= count_ff + 1'b1;
                cmp_ff   <= (count_ff + 1'b1) == i_compare;
                ovf_ff   <= (count_ff + 1'b1) == {WIDTH{1'b1}};
            end
        end
    end

    assign o_count          = count_ff;
    assign o_compare_event  = cmp_ff;
    assign o_overflow_event = ovf_ff;
endmodule : hall_capture_timer

/* verilog/motor_protect_top.sv */
// motor protection trigger logic with apb register slave
`timescale 1ns/1ps
module motor_protect_top
    import motor_protect_pkg::*;
#(
    parameter int TIMER_WIDTH = 16
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // protection inputs
    input  wire logic        i_overcurrent_cmp,
    input  wire logic        i_current_limit_event,
    input  wire logic        i_adc_sel_amplifier,
    input  wire logic        i_pwm_period_start,
    input  wire logic        i_hall_input_a,
    input  wire logic        i_hall_input_b,
    input  wire logic        i_hall_input_c,
    input  wire logic [5:0]  i_polarity_drive,
    // protection outputs
    output logic             o_protect_active,
    output logic             o_overcurrent_cutoff_active,
    output logic [5:0]       o_gate_drive
);
    typedef enum logic [2:0] {
        LIM_IDLE = 3'b001,
        LIM_TRIP = 3'b010,
        LIM_WAIT = 3'b100
    } lim_state_t;

    ctrl_one_t              ctrl_ff;
    mode_sel_t              mode_ff;
    logic [5:0]             cutoff_output_pattern_ff;
    logic [TIMER_WIDTH-1:0] hall_cmp_ff;
    logic [TIMER_WIDTH-1:0] hall_count;
    logic                   hw_cut_en_prev_ff;
    logic                   cut_latch_ff;
    logic                   compare_pause_ff;
    logic                   overflow_pause_ff;
    logic                   oc_pause_ff;
    logic                   sw_pause_ff;
    lim_state_t             lim_state_ff;
    lim_state_t             nxt_lim_state;
    logic                   protect_ff;
    logic                   cutoff_ff;
    logic [5:0]             drive_ff;
    logic [31:0]            prdata_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    trig_t                  trig;
    status_t                status;
    logic                   wr_en;
    logic                   setup;
    logic                   addr_ok;
    logic                   sw_release;
    logic                   limit_active;
    logic                   nxt_protect;
    logic                   nxt_cutoff;
    logic [31:0]            rd_mux;

    // over-current comparator filter
    oc_pulse_filter u_oc_filter (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_cmp_out (i_overcurrent_cmp),
        .o_level   (trig.overcurrent_level),
        .o_pulse   (trig.overcurrent_pulse)
    );

    // hall period supervision
    hall_capture_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_hall_timer (
        .i_clk_sys        (i_clk_sys),
        .i_rst_n          (i_rst_n),
        .i_enable         (mode_ff.hall_timer_enable),
        .i_hall           ({i_hall_input_c, i_hall_input_b, i_hall_input_a}),
        .i_compare        (hall_cmp_ff),
        .o_count          (hall_count),
        .o_compare_event  (trig.hall_compare_event),
        .o_overflow_event (trig.hall_overflow_event)
    );

    // limiter counts only while the converter samples the amplifier
    assign trig.current_limit_event = i_current_limit_event & i_adc_sel_amplifier;

    // apb decode; a write lands at the access edge with pready high
    assign setup   = i_psel & ~i_penable;
    assign wr_en   = i_psel & i_penable & pready_ff & i_pwrite & ~pslverr_ff;
    assign addr_ok = (i_paddr == OFS_CTRL_ONE) || (i_paddr == OFS_MODE_SEL) ||
                     (i_paddr == OFS_CUT_PATTERN) || (i_paddr == OFS_HALL_CMP) ||
                     (i_paddr == OFS_STATUS) || (i_paddr == OFS_HALL_COUNT);

    assign status = '{reserved: 2'h0, limit_hold: (lim_state_ff != LIM_IDLE),
                      sw_pause: sw_pause_ff, overflow_pause: overflow_pause_ff,
                      compare_pause: compare_pause_ff,
                      overcurrent_cutoff_active: cutoff_ff, protect_active: protect_ff};

    // read mux, unmapped reads as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            OFS_CTRL_ONE:    rd_mux = {24'h00_0000, ctrl_ff};
            OFS_MODE_SEL:    rd_mux = {24'h00_0000, mode_ff};
            OFS_CUT_PATTERN: rd_mux = {26'h000_0000, cutoff_output_pattern_ff};
            OFS_HALL_CMP:    rd_mux = 32'(hall_cmp_ff);
            OFS_STATUS:      rd_mux = {24'h00_0000, status};
            OFS_HALL_COUNT:  rd_mux = 32'(hall_count);
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // answer prepared in setup, shown during the one access cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~addr_ok;
            prdata_ff  <= (setup && !i_pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // software registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl_ff                  <= RST_CTRL_ONE;
            mode_ff                  <= RST_MODE_SEL;
            cutoff_output_pattern_ff <= RST_CUT_PATTERN;
            hall_cmp_ff              <= RST_HALL_CMP[TIMER_WIDTH-1:0];
        end else if (wr_en) begin
            case (i_paddr)
                OFS_CTRL_ONE:    ctrl_ff                  <= i_pwdata[7:0];
                OFS_MODE_SEL:    mode_ff                  <= {i_pwdata[7:1], 1'b0};
                OFS_CUT_PATTERN: cutoff_output_pattern_ff <= i_pwdata[5:0];
                OFS_HALL_CMP:    hall_cmp_ff              <= i_pwdata[TIMER_WIDTH-1:0];
                default:         ctrl_ff                  <= ctrl_ff;
            endcase
        end
    end

    // software release level, only with the software path enabled
    assign sw_release = ctrl_ff.sw_protect_enable & ~ctrl_ff.sw_protect_data;

    // pause-mode holds; set wins over the software release
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            compare_pause_ff  <= 1'b0;
            overflow_pause_ff <= 1'b0;
            oc_pause_ff       <= 1'b0;
            sw_pause_ff       <= 1'b0;
        end else begin
            if (trig.hall_compare_event && ctrl_ff.compare_hw_trigger_enable
                && mode_ff.compare_mode_select) begin
                compare_pause_ff <= 1'b1;
            end else if (sw_release) begin
                compare_pause_ff <= 1'b0;
            end
            if (trig.hall_overflow_event && ctrl_ff.overflow_hw_trigger_enable
                && mode_ff.overflow_mode_select) begin
                overflow_pause_ff <= 1'b1;
            end else if (sw_release) begin
                overflow_pause_ff <= 1'b0;
            end
            // pause on over-current is legal but noise makes it stick
            if (trig.overcurrent_pulse && ctrl_ff.overcurrent_hw_trigger_enable
                && mode_ff.overcurrent_mode_select) begin
                oc_pause_ff <= 1'b1;
            end else if (sw_release) begin
                oc_pause_ff <= 1'b0;
            end
            // software trigger only exists in pause mode
            if (ctrl_ff.sw_protect_enable && ctrl_ff.sw_protect_data
                && mode_ff.sw_mode_select) begin
                sw_pause_ff <= 1'b1;
            end else if (sw_release) begin
                sw_pause_ff <= 1'b0;
            end
        end
    end

    // limiter hold and restart sequencing
    always_comb begin
        nxt_lim_state = lim_state_ff;
        case (lim_state_ff)
            LIM_IDLE: begin
                if (trig.current_limit_event && ctrl_ff.limit_hw_trigger_enable) begin
                    nxt_lim_state = LIM_TRIP;
                end
            end
            LIM_TRIP: begin
                if (!(trig.current_limit_event && ctrl_ff.limit_hw_trigger_enable)) begin
                    // restart select 1 parks until the period boundary
                    nxt_lim_state = mode_ff.limit_restart_select ? LIM_WAIT
                                                                 : LIM_IDLE;
                end
            end
            LIM_WAIT: begin
                if (trig.current_limit_event && ctrl_ff.limit_hw_trigger_enable) begin
                    nxt_lim_state = LIM_TRIP;
                end else if (i_pwm_period_start) begin
                    nxt_lim_state = LIM_IDLE;
                end
            end
            default: nxt_lim_state = LIM_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            lim_state_ff <= LIM_IDLE;
        end else begin
            lim_state_ff <= nxt_lim_state;
        end
    end

    assign limit_active = (lim_state_ff != LIM_IDLE);

    // fault sources follow their condition; pause sources stay held
    always_comb begin
        nxt_protect = compare_pause_ff | overflow_pause_ff | oc_pause_ff | sw_pause_ff
                    | limit_active
                    | (trig.overcurrent_level & ctrl_ff.overcurrent_hw_trigger_enable
                       & ~mode_ff.overcurrent_mode_select)
                    | (trig.hall_compare_event & ctrl_ff.compare_hw_trigger_enable
                       & ~mode_ff.compare_mode_select)
                    | (trig.hall_overflow_event & ctrl_ff.overflow_hw_trigger_enable
                       & ~mode_ff.overflow_mode_select);
    end

    // hardware cutoff latch: pulse sets, enable rising edge clears
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hw_cut_en_prev_ff <= 1'b0;
            cut_latch_ff      <= 1'b0;
        end else begin
            hw_cut_en_prev_ff <= ctrl_ff.hw_cutoff_enable;
            if (trig.overcurrent_pulse && ctrl_ff.overcurrent_hw_trigger_enable
                && ctrl_ff.hw_cutoff_enable) begin
                cut_latch_ff <= 1'b1;
            end else if (ctrl_ff.hw_cutoff_enable && !hw_cut_en_prev_ff) begin
                cut_latch_ff <= 1'b0;
            end
        end
    end

    // software path forces cutoff as a plain level
    assign nxt_cutoff = cut_latch_ff | ctrl_ff.sw_cutoff_enable;

    // output stage: cutoff beats protect beats polarity drive
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            protect_ff <= 1'b0;
            cutoff_ff  <= 1'b0;
            drive_ff   <= PATTERN_FREE_RUN;
        end else begin
            protect_ff <= nxt_protect;
            cutoff_ff  <= nxt_cutoff;
            if (nxt_cutoff) begin
                drive_ff <= cutoff_output_pattern_ff;
            end else if (nxt_protect) begin
                drive_ff <= mode_ff.stop_style_select ? PATTERN_FREE_RUN
                                                      : PATTERN_BRAKE;
            end else begin
                drive_ff <= i_polarity_drive;
            end
        end
    end

    assign o_prdata                    = prdata_ff;
    assign o_pready                    = pready_ff;
    assign o_pslverr                   = pslverr_ff;
    assign o_protect_active            = protect_ff;
    assign o_overcurrent_cutoff_active = cutoff_ff;
    assign o_gate_drive                = drive_ff;
endmodule : motor_protect_top

/* verif/motor_protect_checker.sv */
// concurrent checks on the motor protection top ports
`timescale 1ns/1ps
module motor_protect_checker
    import motor_protect_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [5:0]  i_polarity_drive,
    input wire logic        o_protect_active,
    input wire logic        o_overcurrent_cutoff_active,
    input wire logic [5:0]  o_gate_drive
);
    logic       wr_go;
    logic       run_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [5:0] pat_ff;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // a write lands at the edge that samples pready
    assign wr_go = i_psel && i_penable && o_pready && i_pwrite;
    // register shadows; run_ff masks the first edge after reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            run_ff  <= 1'b0;
            ctrl_ff <= 8'h00;
            mode_ff <= 8'h00;
            pat_ff  <= 6'h00;
        end else begin
            run_ff <= 1'b1;
            if (wr_go && i_paddr == OFS_CTRL_ONE) ctrl_ff <= i_pwdata[7:0];
            if (wr_go && i_paddr == OFS_MODE_SEL) mode_ff <= i_pwdata[7:0];
            if (wr_go && i_paddr == OFS_CUT_PATTERN) pat_ff <= i_pwdata[5:0];
        end
    end
    pready_follow_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    pready_place_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("pready outside access");
    slverr_unmapped_a: assert property (o_pready && i_paddr == 8'hFC |-> o_pslverr)
        else $error("no error on unmapped address");
    sw_cutoff_set_a: assert property (
        wr_go && i_paddr == OFS_CTRL_ONE && i_pwdata[1] |-> ##[1:2] o_overcurrent_cutoff_active)
        else $error("software cutoff not asserted");
    cutoff_hold_a: assert property (
        $fell(o_overcurrent_cutoff_active) |-> $past(wr_go) || $past(wr_go, 2) || $past(wr_go, 3))
        else $error("cutoff dropped without a write");
    trigger_gate_a: assert property (
        $rose(o_protect_active) |-> ($past(ctrl_ff[6:2]) | $past(ctrl_ff[6:2], 2)) != 5'h00)
        else $error("protect set with every source disabled");
    cutoff_pattern_a: assert property (
        o_overcurrent_cutoff_active && $past(o_overcurrent_cutoff_active)
        |-> o_gate_drive == $past(pat_ff)) else $error("cutoff pattern not driven");
    stop_style_a: assert property (
        o_protect_active && $past(o_protect_active) && !o_overcurrent_cutoff_active
        && !$past(o_overcurrent_cutoff_active) |-> o_gate_drive
        == ($past(mode_ff[6]) ? PATTERN_FREE_RUN : PATTERN_BRAKE)) else $error("bad stop style");
    normal_drive_a: assert property (
        run_ff && !ctrl_ff[2] && !o_protect_active && !$past(o_protect_active)
        && !o_overcurrent_cutoff_active && !$past(o_overcurrent_cutoff_active)
        |-> o_gate_drive == $past(i_polarity_drive)) else $error("polarity drive not passed");
endmodule : motor_protect_checker

bind motor_protect_top motor_protect_checker u_chk (.i_clk_sys, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_polarity_drive,
    .o_protect_active, .o_overcurrent_cutoff_active, .o_gate_drive);

/* verif/gate_stage_model.sv */
// power stage model whose short circuit trips the current comparator
`timescale 1ns/1ps
module gate_stage_model (
    input  wire logic       i_clk_sys,
    input  wire logic [5:0] i_gate_drive,
    input  wire logic       i_short,
    output logic            o_oc_cmp
);
    // current flows only while some transistor still conducts
    always_ff @(posedge i_clk_sys) begin
        o_oc_cmp <= i_short && (i_gate_drive != 6'h00);
    end
endmodule : gate_stage_model

/* verif/motor_protection_trigger_logic_tb_top.sv */
// self-checking bench for the motor protection block
`timescale 1ns/1ps
module motor_protection_trigger_logic_tb_top;
    import motor_protect_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sh, oc, lim, amp, pws, prot, cut;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v, d;
    logic [2:0]  hall;
    logic [5:0]  pol, gate, pat, p;
    logic        rd_e;
    int          err_count, n_compared, s;
    motor_protect_top #(.TIMER_WIDTH(8)) dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_overcurrent_cmp(oc),
        .i_current_limit_event(lim), .i_adc_sel_amplifier(amp), .i_pwm_period_start(pws),
        .i_hall_input_a(hall[0]), .i_hall_input_b(hall[1]), .i_hall_input_c(hall[2]),
        .i_polarity_drive(pol), .o_protect_active(prot), .o_overcurrent_cutoff_active(cut),
        .o_gate_drive(gate));
    gate_stage_model u_stage (.i_clk_sys(clk), .i_gate_drive(gate), .i_short(sh), .o_oc_cmp(oc));
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // random polarity drive, never all off so a short draws current
    always @(posedge clk) pol <= 6'($urandom) | 6'h01;
    function automatic logic [5:0] stop_pat(input logic free);
        return free ? PATTERN_FREE_RUN : PATTERN_BRAKE;
    endfunction : stop_pat
    function automatic logic sig(input int sel);
        return (sel != 0) ? cut : prot;
    endfunction : sig
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", pready, 1);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask : rd
    // wait a bounded time for a level, then compare
    task automatic await(input string nm, input int sel, input logic v, input int mx);
        int n;
        n = 0;
        while (sig(sel) !== v && n < mx) begin
            @(posedge clk);
            n++;
        end
        chk(nm, sig(sel), v);
    endtask : await
    task automatic hold(input string nm, input int sel, input logic v, input int c);
        repeat (c) begin
            @(posedge clk);
            chk(nm, sig(sel), v);
        end
    endtask : hold
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end
    initial begin
        {rst_n, psel, penable, pwrite, sh, lim, amp, pws} = '0;
        {paddr, pwdata, hall, pol} = '0;
        void'($urandom(76020));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl_rst", OFS_CTRL_ONE, {24'h0, RST_CTRL_ONE});
        rd("cmp_rst", OFS_HALL_CMP, {24'h0, RST_HALL_CMP[7:0]});
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", rd_e, 1);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(OFS_CUT_PATTERN, d);
            rd("pattern", OFS_CUT_PATTERN, {26'h0, d[5:0]});
        end
        pat = d[5:0];
        done("registers");
        wr(OFS_CTRL_ONE, 32'h02);
        await("sw_cut_on", 1, 1, 4);
        chk("cut_gate", gate, pat);
        wr(OFS_CTRL_ONE, 32'h00);
        await("sw_cut_off", 1, 0, 4);
        done("sw_cutoff");
        wr(OFS_CTRL_ONE, 32'h01);
        sh <= 1'b1;
        hold("no_oc_enable", 1, 0, 12);
        sh <= 1'b0;
        wr(OFS_CTRL_ONE, 32'h08);
        wr(OFS_CTRL_ONE, 32'h09);
        sh <= 1'b1;
        @(posedge clk);
        sh <= 1'b0;
        hold("glitch", 1, 0, 12);
        sh <= 1'b1;
        await("hw_cut_on", 1, 1, 12);
        sh <= 1'b0;
        hold("cut_latched", 1, 1, 10);
        wr(OFS_CTRL_ONE, 32'h08);
        wr(OFS_CTRL_ONE, 32'h09);
        await("hw_cut_clear", 1, 0, 4);
        wr(OFS_CTRL_ONE, 32'h00);
        done("hw_cutoff");
        lim <= 1'b1;
        amp <= 1'b1;
        hold("lim_off", 0, 0, 5);
        amp <= 1'b0;
        wr(OFS_CTRL_ONE, 32'h04);
        hold("lim_no_amp", 0, 0, 5);
        lim <= 1'b0;
        amp <= 1'b1;
        for (s = 0; s < 2; s++) begin
            wr(OFS_MODE_SEL, 32'(s) << 6);
            lim <= 1'b1;
            await("lim_on", 0, 1, 4);
            @(posedge clk);
            chk("stop_style", gate, stop_pat(s[0]));
            lim <= 1'b0;
            await("lim_restart", 0, 0, 4);
        end
        wr(OFS_MODE_SEL, 32'h10);
        lim <= 1'b1;
        await("lim_on_hold", 0, 1, 4);
        lim <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            chk("lim_held", gate, PATTERN_BRAKE);
        end
        pws <= 1'b1;
        @(posedge clk);
        pws <= 1'b0;
        repeat (3) @(posedge clk);
        p = pol;
        @(posedge clk);
        chk("lim_resumed", gate, p);
        wr(OFS_CTRL_ONE, 32'h00);
        done("limiter");
        wr(OFS_MODE_SEL, 32'h20);
        wr(OFS_CTRL_ONE, 32'h80);
        hold("sw_disabled", 0, 0, 5);
        wr(OFS_CTRL_ONE, 32'hC0);
        await("sw_pause_on", 0, 1, 4);
        wr(OFS_CTRL_ONE, 32'h00);
        hold("pause_kept", 0, 1, 5);
        wr(OFS_CTRL_ONE, 32'h40);
        await("sw_release", 0, 0, 4);
        done("sw_protect");
        wr(OFS_HALL_CMP, 32'h20);
        wr(OFS_MODE_SEL, 32'h84);
        wr(OFS_CTRL_ONE, 32'h00);
        hall <= hall ^ 3'h1;
        hold("cmp_off", 0, 0, 60);
        wr(OFS_CTRL_ONE, 32'h10);
        hall <= hall ^ 3'h1;
        await("cmp_on", 0, 1, 60);
        hold("cmp_paused", 0, 1, 40);
        wr(OFS_CTRL_ONE, 32'h40);
        await("cmp_release", 0, 0, 4);
        wr(OFS_MODE_SEL, 32'h82);
        wr(OFS_CTRL_ONE, 32'h20);
        hall <= hall ^ 3'h2;
        await("ovf_on", 0, 1, 300);
        wr(OFS_CTRL_ONE, 32'h40);
        await("ovf_release", 0, 0, 4);
        done("hall_timer");
        give_verdict();
    end
endmodule : motor_protection_trigger_logic_tb_top
